/* hdl/ccl_coulomb_counter.sv */
`timescale 1ns/1ns
`default_nettype none
module ccl_coulomb_counter (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // analog front end, asynchronous
  input wire logic count_pulse_in,
  input wire logic sense_positive_in,
  // latch sources, asynchronous event levels
  input wire logic adc_busy_in,
  input wire logic general_timer_ovf_in,
  input wire logic second_timer_ovf_in,
  // primary config
  input wire logic gauge_power_on,
  input wire logic sense_input_short,
  input wire logic [1:0] latch_source_select,
  // command register write
  input wire logic cmd_write,
  input wire logic [7:0] gauge_command_reg,
  // status and latched bytes
  output logic current_direction_status,
  output logic direction_change_flag,
  output logic charge_wrap_flag,
  output logic discharge_wrap_flag,
  output logic [7:0] charge_latch_low_byte,
  output logic [7:0] charge_latch_high_byte,
  output logic [7:0] discharge_latch_low_byte,
  output logic [7:0] discharge_latch_high_byte
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  // two flops settle metastability, a third keeps the edge history
  localparam int unsigned NSYNC = ccl_pkg::SYNC_LANES;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync_q1_r;
  logic [NSYNC-1:0] sync_q2_r;
  logic [NSYNC-1:0] sync_prev_r;
  logic [NSYNC-1:0] sync_q1_nxt;
  logic [NSYNC-1:0] sync_q2_nxt;
  logic [NSYNC-1:0] sync_prev_nxt;

  assign async_in = {second_timer_ovf_in, general_timer_ovf_in, adc_busy_in,
                     sense_positive_in, count_pulse_in};

  always_comb begin
    sync_q1_nxt = async_in;
    sync_q2_nxt = sync_q1_r;
    sync_prev_nxt = sync_q2_r;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync_q1_r <= '0;
      sync_q2_r <= '0;
      sync_prev_r <= '0;
    end else begin
      sync_q1_r <= sync_q1_nxt;
      sync_q2_r <= sync_q2_nxt;
      sync_prev_r <= sync_prev_nxt;
    end
  end

  // ------------------------------------------------------------
  // edge detection
  // ------------------------------------------------------------
  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction : rise

  logic pulse_ev;
  logic dir_now;
  logic dir_prev;
  logic adc_start_ev;
  logic adc_end_ev;
  logic gtmr_ev;
  logic stmr_ev;

  // shorted sense inputs see zero volts: no pulses reach the counters
  assign pulse_ev = gauge_power_on & ~sense_input_short &
                    rise(sync_q2_r[ccl_pkg::LANE_PULSE], sync_prev_r[ccl_pkg::LANE_PULSE]);
  assign dir_now = sync_q2_r[ccl_pkg::LANE_DIR];
  assign dir_prev = sync_prev_r[ccl_pkg::LANE_DIR];
  assign adc_start_ev = rise(sync_q2_r[ccl_pkg::LANE_ADC], sync_prev_r[ccl_pkg::LANE_ADC]);
  assign adc_end_ev = rise(sync_prev_r[ccl_pkg::LANE_ADC], sync_q2_r[ccl_pkg::LANE_ADC]);
  assign gtmr_ev = rise(sync_q2_r[ccl_pkg::LANE_GTMR], sync_prev_r[ccl_pkg::LANE_GTMR]);
  assign stmr_ev = rise(sync_q2_r[ccl_pkg::LANE_STMR], sync_prev_r[ccl_pkg::LANE_STMR]);

  // ------------------------------------------------------------
  // command decode and latch source mux
  // ------------------------------------------------------------
  ccl_pkg::ccl_src_t src;
  logic cpu_mode;
  logic snap_ev;
  logic clr_chg;
  logic clr_dis;

  // no guard across a source change: latches from the old source are stale
  assign src = ccl_pkg::ccl_src_t'(latch_source_select);
  assign cpu_mode = (src == ccl_pkg::CCL_SRC_CPU);
  assign clr_chg = cpu_mode & cmd_write & gauge_command_reg[ccl_pkg::CLR_CHG_BIT];
  assign clr_dis = cpu_mode & cmd_write & gauge_command_reg[ccl_pkg::CLR_DIS_BIT];

  always_comb begin
    unique case (src)
      ccl_pkg::CCL_SRC_CPU: snap_ev = cmd_write & gauge_command_reg[ccl_pkg::SNAP_BIT];
      ccl_pkg::CCL_SRC_ADC: snap_ev = adc_start_ev | adc_end_ev;
      ccl_pkg::CCL_SRC_GTMR: snap_ev = gtmr_ev;
      ccl_pkg::CCL_SRC_STMR: snap_ev = stmr_ev;
    endcase
  end

  // ------------------------------------------------------------
  // counters, latches and status
  // ------------------------------------------------------------
  logic [15:0] chg_cnt_r;
  logic [15:0] chg_cnt_nxt;
  logic [15:0] dis_cnt_r;
  logic [15:0] dis_cnt_nxt;
  logic [15:0] chg_lat_r;
  logic [15:0] chg_lat_nxt;
  logic [15:0] dis_lat_r;
  logic [15:0] dis_lat_nxt;
  logic dir_r;
  logic dir_nxt;
  logic dir_flag_r;
  logic dir_flag_nxt;
  logic chg_wrap_r;
  logic chg_wrap_nxt;
  logic dis_wrap_r;
  logic dis_wrap_nxt;
  logic inc_chg;
  logic inc_dis;

  assign inc_chg = pulse_ev & dir_now;
  assign inc_dis = pulse_ev & ~dir_now;

  always_comb begin
    chg_cnt_nxt = chg_cnt_r;
    dis_cnt_nxt = dis_cnt_r;
    chg_wrap_nxt = 1'h0;
    dis_wrap_nxt = 1'h0;
    // a clear beats a same-cycle count, which is then lost
    if (clr_chg) begin
      chg_cnt_nxt = ccl_pkg::CNT_RESET;
    end else if (inc_chg) begin
      chg_cnt_nxt = chg_cnt_r + ccl_pkg::CNT_ONE;
      chg_wrap_nxt = (chg_cnt_r == ccl_pkg::CNT_MAX);
    end
    if (clr_dis) begin
      dis_cnt_nxt = ccl_pkg::CNT_RESET;
    end else if (inc_dis) begin
      dis_cnt_nxt = dis_cnt_r + ccl_pkg::CNT_ONE;
      dis_wrap_nxt = (dis_cnt_r == ccl_pkg::CNT_MAX);
    end
    // latch captures settled registers, never a value mid-increment
    chg_lat_nxt = snap_ev ? chg_cnt_r : chg_lat_r;
    dis_lat_nxt = snap_ev ? dis_cnt_r : dis_lat_r;
    dir_nxt = dir_now;
    dir_flag_nxt = (dir_now != dir_prev);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chg_cnt_r <= ccl_pkg::CNT_RESET;
      dis_cnt_r <= ccl_pkg::CNT_RESET;
      chg_lat_r <= ccl_pkg::CNT_RESET;
      dis_lat_r <= ccl_pkg::CNT_RESET;
      dir_r <= 1'h0;
      dir_flag_r <= 1'h0;
      chg_wrap_r <= 1'h0;
      dis_wrap_r <= 1'h0;
    end else begin
      chg_cnt_r <= chg_cnt_nxt;
      dis_cnt_r <= dis_cnt_nxt;
      chg_lat_r <= chg_lat_nxt;
      dis_lat_r <= dis_lat_nxt;
      dir_r <= dir_nxt;
      dir_flag_r <= dir_flag_nxt;
      chg_wrap_r <= chg_wrap_nxt;
      dis_wrap_r <= dis_wrap_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign current_direction_status = dir_r;
  assign direction_change_flag = dir_flag_r;
  assign charge_wrap_flag = chg_wrap_r;
  assign discharge_wrap_flag = dis_wrap_r;
  assign charge_latch_low_byte = chg_lat_r[ccl_pkg::BYTE_W-1:0];
  assign charge_latch_high_byte = chg_lat_r[ccl_pkg::CNT_W-1:ccl_pkg::BYTE_W];
  assign discharge_latch_low_byte = dis_lat_r[ccl_pkg::BYTE_W-1:0];
  assign discharge_latch_high_byte = dis_lat_r[ccl_pkg::CNT_W-1:ccl_pkg::BYTE_W];

endmodule : ccl_coulomb_counter
`default_nettype wire

/* hdl/ccl_pkg.sv */
package ccl_pkg;
  // counter geometry
  localparam int unsigned CNT_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // field positions of the primary config and command bytes
  localparam int unsigned SEL_LO_BIT = 4;
  localparam int unsigned SEL_HI_BIT = 5;
  localparam int unsigned SNAP_BIT = 7;
  localparam int unsigned CLR_DIS_BIT = 6;
  localparam int unsigned CLR_CHG_BIT = 5;
  // synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;
  // lane positions within the synchroniser vector
  localparam int unsigned SYNC_LANES = 5;
  localparam int unsigned LANE_PULSE = 0;
  localparam int unsigned LANE_DIR = 1;
  localparam int unsigned LANE_ADC = 2;
  localparam int unsigned LANE_GTMR = 3;
  localparam int unsigned LANE_STMR = 4;

  typedef enum logic [1:0] {
    CCL_SRC_CPU = 2'h0,
    CCL_SRC_ADC = 2'h1,
    CCL_SRC_GTMR = 2'h2,
    CCL_SRC_STMR = 2'h3
  } ccl_src_t;
endpackage : ccl_pkg

/* dv/ccl_chk_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module ccl_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // controls
  input wire logic sense_positive_in,
  input wire logic gauge_power_on,
  input wire logic sense_input_short,
  input wire logic [1:0] latch_source_select,
  input wire logic cmd_write,
  input wire logic [7:0] gauge_command_reg,
  // status and latches
  input wire logic current_direction_status,
  input wire logic direction_change_flag,
  input wire logic charge_wrap_flag,
  input wire logic discharge_wrap_flag,
  input wire logic [7:0] charge_latch_low_byte,
  input wire logic [7:0] discharge_latch_low_byte
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic snap = cmd_write && gauge_command_reg[7];
  wire logic wrap = charge_wrap_flag || discharge_wrap_flag;
  a_reset_clear: assert property ($fell(rst) |-> charge_latch_low_byte == 8'h00 &&
    discharge_latch_low_byte == 8'h00) else $error("latch not clear");
  a_dir_high: assert property (sense_positive_in [*5] |=> current_direction_status)
    else $error("status not high");
  a_dir_low: assert property (!sense_positive_in [*5] |=> !current_direction_status)
    else $error("status not low");
  a_dir_flag: assert property ($changed(current_direction_status) |-> ##[0:1]
    direction_change_flag) else $error("no direction flag");
  a_flag_once: assert property (direction_change_flag |=> !direction_change_flag)
    else $error("direction flag too long");
  a_wrap_once: assert property (wrap |=> !wrap) else $error("wrap flag too long");
  a_wrap_gate: assert property ((!gauge_power_on || sense_input_short) [*4] |-> !wrap)
    else $error("count while off");
  a_cpu_hold: assert property ((latch_source_select == 2'h0) [*5] ##0 !snap |=>
    $stable(charge_latch_low_byte) && $stable(discharge_latch_low_byte)) else $error("latch moved");
  c_snap: cover property (snap && latch_source_select == 2'h0);
  c_dir: cover property (direction_change_flag);
  c_src: cover property (latch_source_select == 2'h3 && $changed(charge_latch_low_byte));
endmodule : ccl_chk
bind ccl_coulomb_counter ccl_chk u_chk (
  .ref_clk(ref_clk),
  .rst(rst),
  .sense_positive_in(sense_positive_in),
  .gauge_power_on(gauge_power_on),
  .sense_input_short(sense_input_short),
  .latch_source_select(latch_source_select),
  .cmd_write(cmd_write),
  .gauge_command_reg(gauge_command_reg),
  .current_direction_status(current_direction_status),
  .direction_change_flag(direction_change_flag),
  .charge_wrap_flag(charge_wrap_flag),
  .discharge_wrap_flag(discharge_wrap_flag),
  .charge_latch_low_byte(charge_latch_low_byte),
  .discharge_latch_low_byte(discharge_latch_low_byte)
);
`default_nettype wire

/* dv/ccl_vf_model.sv */
`timescale 1ns/1ns
`default_nettype none
module ccl_vf_model (
  input wire logic ref_clk,
  output logic count_pulse_in
);
  initial count_pulse_in = 1'b0;
  // each count held three clocks high, then four low before the next count
  task automatic burst(input int n);
    repeat (n) begin
      @(negedge ref_clk);
      count_pulse_in = 1'b1;
      repeat (3) @(negedge ref_clk);
      count_pulse_in = 1'b0;
      repeat (3) @(negedge ref_clk);
    end
  endtask : burst
endmodule : ccl_vf_model
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic ref_clk = 0, rst = 1, spos = 1, adc = 0, gto = 0, sto = 0, pwr = 0, shrt = 0, cw = 0;
  logic [1:0] sel = 2'h0;
  logic [7:0] cmd = 8'h00, cl, ch, dl, dh;
  logic [15:0] ec = 0, ed = 0, lc = 0, ld = 0;
  logic [39:0] q[$];
  logic cds, dcf, cwf, dwf;
  logic irq_dir_en = 0;
  int dir_irqs = 0, exp_irqs = 0;
  wire logic pulse;
  int mismatches = 0, n_tests = 0, cyc = 0;
  event smp;
  ccl_vf_model vf (.ref_clk(ref_clk), .count_pulse_in(pulse));
  ccl_coulomb_counter uut (.ref_clk(ref_clk), .rst(rst), .count_pulse_in(pulse),
    .sense_positive_in(spos), .adc_busy_in(adc), .general_timer_ovf_in(gto),
    .second_timer_ovf_in(sto), .gauge_power_on(pwr), .sense_input_short(shrt),
    .latch_source_select(sel), .cmd_write(cw), .gauge_command_reg(cmd),
    .current_direction_status(cds), .direction_change_flag(dcf), .charge_wrap_flag(cwf),
    .discharge_wrap_flag(dwf), .charge_latch_low_byte(cl), .charge_latch_high_byte(ch),
    .discharge_latch_low_byte(dl), .discharge_latch_high_byte(dh));
  initial forever #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 20000) begin
      mismatches++;
      final_report();
    end
  end
  // cpu side: masked direction interrupts and flags seen mid-cycle
  always @(negedge ref_clk) begin
    if (dcf === 1'b1 && irq_dir_en) dir_irqs++;
    if (cwf !== 1'b0 || dwf !== 1'b0) begin
      mismatches++;
      $display("unexpected at %0t: wrap flag without a wrap", $time);
    end
  end
  always @(smp) begin
    n_tests++;
    if ({3'h0, cds, 4'(dir_irqs), ch, cl, dh, dl} !== q.pop_front()) begin
      mismatches++;
      $display("unexpected at %0t: status %h latches %h", $time, {cds, 4'(dir_irqs)},
               {ch, cl, dh, dl});
    end
    $display("test %0d done", n_tests);
  end
  task automatic cmdw(input logic [7:0] v);
    @(negedge ref_clk);
    cw = 1'b1;
    cmd = v;
    @(negedge ref_clk);
    cw = 1'b0;
  endtask : cmdw
  task automatic expect_latch(input logic [15:0] c, input logic [15:0] d);
    repeat (6) @(negedge ref_clk);
    lc = c;
    ld = d;
    q.push_back({3'h0, spos, 4'(exp_irqs), c, d});
    -> smp;
  endtask : expect_latch
  task automatic burst(input int n, input logic cnt);
    repeat (4) @(negedge ref_clk);
    vf.burst(n);
    if (cnt && spos) ec += 16'(n);
    if (cnt && !spos) ed += 16'(n);
  endtask : burst
  task automatic fire(input int s, input logic v);
    @(negedge ref_clk);
    if (s == 1) adc = v;
    else if (s == 2) gto = v;
    else sto = v;
  endtask : fire
  task automatic final_report;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  initial begin
    void'($urandom(76));
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    expect_latch(lc, ld);
    pwr = 1'b1;
    irq_dir_en = 1'b1;
    for (int i = 0; i < 2; i++) begin
      spos = ~spos;
      exp_irqs++;
      burst($urandom_range(9, 1), 1'b1);
      cmdw(8'h80);
      cmdw(8'h80);
      expect_latch(ec, ed);
    end
    pwr = 1'b0;
    burst(2, 1'b0);
    pwr = 1'b1;
    shrt = 1'b1;
    burst(2, 1'b0);
    shrt = 1'b0;
    cmdw(8'h20);
    ec = 16'h0000;
    cmdw(8'h80);
    expect_latch(ec, ed);
    cmdw(8'h40);
    ed = 16'h0000;
    for (int s = 1; s < 4; s++) begin
      sel = s[1:0];
      burst($urandom_range(5, 1), 1'b1);
      cmdw(8'he0);
      expect_latch(lc, ld);
      fire(s, 1'b1);
      expect_latch(ec, ed);
      burst(2, 1'b1);
      fire(s, 1'b0);
      if (s == 1) expect_latch(ec, ed);
      else expect_latch(lc, ld);
    end
    // second reset in mid-run: the cpu mask clears with it
    sel = 2'h0;
    irq_dir_en = 1'b0;
    rst = 1'b1;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    ec = 16'h0000;
    ed = 16'h0000;
    expect_latch(16'h0000, 16'h0000);
    irq_dir_en = 1'b1;
    burst($urandom_range(9, 1), 1'b1);
    cmdw(8'h80);
    expect_latch(ec, ed);
    final_report();
  end
endmodule : tb
`default_nettype wire
